// File: memory_map_defs.vh
// Address map constants for the memory map decoder.
// Assumes 24-bit byte addresses and 16-bit data lanes.
`ifndef MEMORY_MAP_DEFS_VH
`define MEMORY_MAP_DEFS_VH

// ==========================================================
// Address structure
// ==========================================================
`define ADDR_W 24
`define SEG_HI 23
`define SEG_LO 16
`define PAGE_HI 15
`define PAGE_LO 14
`define OFS_HI 13
`define SYS_SEG 8'h00

// ==========================================================
// Region bounds (inclusive)
// ==========================================================
`define TOP_REG_LO 24'hffff00
`define TRAP_LO 24'hf00000
`define EPRAM_LO 24'he80000
`define EPRAM_HI 24'hefffff
`define PROGRAM_SRAM_LO 24'he00000
`define PROGRAM_SRAM_HI 24'he7ffff
`define SRAM_MASK 24'h007fff
`define FLASH_RES_LO 24'hcd0000
`define FLASH_LO 24'hc00000
`define FLASH_HI 24'hdfffff
`define FLASH_INT_LO 24'hc0f000
`define FLASH_INT_HI 24'hc0ffff
`define EXT_MEM2_LO 24'h400000
`define EXT_IO_LO 24'h210000
`define EXT_IO_HI 24'h3fffff
`define LB_RES2_LO 24'h20c000
`define LB_ALT_LO 24'h208000
`define LB_ALT_HI 24'h20bfff
`define LB_RES1_LO 24'h206000
`define LB_SER_LO 24'h204000
`define LB_CAN_LO 24'h200000
`define LB_HI 24'h20ffff
`define EXT_MEM1_LO 24'h010000
`define EXT_MEM1_HI 24'h1fffff
`define SFR_LO 24'h00fe00
`define DUAL_PORT_RAM_LO 24'h00f600
`define DUAL_PORT_RAM_RES_LO 24'h00f200
`define EXTENDED_REGISTER_AREA_LO 24'h00f000
`define PERIPHERAL_REGISTER_AREA_LO 24'h00e000
`define DATA_SRAM_LO 24'h00a000
`define DATA_SRAM_RES_LO 24'h008000
`define DUAL_PORT_RAM_BIT_LO 24'h00fd00
`define ALT_TO_CAN 24'h008000
`define ALT_SER_OFS 24'h004000

// ==========================================================
// Target codes
// ==========================================================
`define TGT_W 4
`define TGT_NONE 4'h0
`define TGT_FLASH 4'h1
`define TGT_PROGRAM_SRAM 4'h2
`define TGT_EPRAM 4'h3
`define TGT_DATA_SRAM 4'h4
`define TGT_DUAL_PORT_RAM 4'h5
`define TGT_SFR 4'h6
`define TGT_EXTENDED_REGISTER_AREA 4'h7
`define TGT_PERIPHERAL_REGISTER_AREA 4'h8
`define TGT_LBUS 4'h9
`define TGT_EXT 4'ha
`define TGT_EXTIO 4'hb
`define TGT_TOPREG 4'hc
`define TGT_TRAP 4'hd

// ==========================================================
// Unit codes and other fields
// ==========================================================
`define UNIT_FETCH 1'b0
`define UNIT_DATA 1'b1
`define GPR_BANK_W 16
`define BIT_W 4
`define WP_W 15

`endif

// File: region_decode.v
// Combinational region decoder for one 24-bit address.
// Assumes the address is stable for the cycle in which it is decoded.
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_defs.vh"

module region_decode (
    input wire [`ADDR_W-1:0] addr,
    output reg [`TGT_W-1:0] target,
    output reg [`ADDR_W-1:0] local_addr,
    output reg bit_ok,
    output reg reserved_flash
);
    always @* begin
        target = `TGT_EXT;
        local_addr = addr;
        bit_ok = 1'b0;
        reserved_flash = 1'b0;
        if (addr >= `TOP_REG_LO) begin
            target = `TGT_TOPREG;
            local_addr = addr - `TOP_REG_LO;
        end else if (addr >= `TRAP_LO) begin
            target = `TGT_TRAP;
        end else if (addr >= `EPRAM_LO) begin
            target = `TGT_EPRAM;
            local_addr = addr & `SRAM_MASK;
        end else if (addr >= `PROGRAM_SRAM_LO) begin
            target = `TGT_PROGRAM_SRAM;
            local_addr = addr & `SRAM_MASK;
        end else if (addr >= `FLASH_RES_LO) begin
            target = `TGT_TRAP;
        end else if (addr >= `FLASH_LO) begin
            target = `TGT_FLASH;
            local_addr = addr - `FLASH_LO;
            reserved_flash = (addr >= `FLASH_INT_LO) && (addr <= `FLASH_INT_HI);
        end else if (addr >= `EXT_MEM2_LO) begin
            target = `TGT_EXT;
        end else if (addr >= `EXT_IO_LO) begin
            target = `TGT_EXTIO;
        end else if (addr >= `LB_RES2_LO) begin
            target = `TGT_TRAP;
        end else if (addr >= `LB_ALT_LO) begin
            target = `TGT_LBUS;
            local_addr = addr - `ALT_TO_CAN;
        end else if (addr >= `LB_RES1_LO) begin
            target = `TGT_TRAP;
        end else if (addr >= `LB_CAN_LO) begin
            target = `TGT_LBUS;
        end else if (addr >= `EXT_MEM1_LO) begin
            target = `TGT_EXT;
        end else if (addr >= `SFR_LO) begin
            target = `TGT_SFR;
            local_addr = addr - `SFR_LO;
            bit_ok = 1'b1;
        end else if (addr >= `DUAL_PORT_RAM_LO) begin
            target = `TGT_DUAL_PORT_RAM;
            local_addr = addr - `DUAL_PORT_RAM_LO;
            bit_ok = (addr >= `DUAL_PORT_RAM_BIT_LO);
        end else if (addr >= `DUAL_PORT_RAM_RES_LO) begin
            target = `TGT_TRAP;
        end else if (addr >= `EXTENDED_REGISTER_AREA_LO) begin
            target = `TGT_EXTENDED_REGISTER_AREA;
            local_addr = addr - `EXTENDED_REGISTER_AREA_LO;
            bit_ok = 1'b1;
        end else if (addr >= `PERIPHERAL_REGISTER_AREA_LO) begin
            target = `TGT_PERIPHERAL_REGISTER_AREA;
            local_addr = addr - `PERIPHERAL_REGISTER_AREA_LO;
        end else if (addr >= `DATA_SRAM_LO) begin
            target = `TGT_DATA_SRAM;
            local_addr = addr - `DATA_SRAM_LO;
        end else if (addr >= `DATA_SRAM_RES_LO) begin
            target = `TGT_TRAP;
        end else begin
            target = `TGT_EXT;
        end
    end
endmodule // region_decode
`default_nettype wire

// File: lane_select.v
// Byte lane enable generator for byte and word accesses.
// Assumes little-endian 16-bit lanes; word accesses ignore address bit 0.
`timescale 1ns/1ps
`default_nettype none

module lane_select (
    input wire addr_lsb,
    input wire is_word,
    output wire [1:0] lanes
);
    assign lanes = is_word ? 2'h3 : (addr_lsb ? 2'h2 : 2'h1);
endmodule // lane_select
`default_nettype wire

// File: memory_map_decoder.v
// Address decoder and router for the unified 16-Mbyte address space.
// Contract
// - Code, data, registers and I/O share one linear address space.
// - 16 Mbytes as 256 segments of 64 Kbytes, upper byte is segment.
// - Each segment holds four 16-Kbyte pages above a 14-bit offset.
// - Every location accepts byte and word accesses with matching lanes.
// - Internal data memories and register areas decode in segment 0.
// - Fetches go through the fetch unit, which owns flash and program SRAM.
// - Data transfers go through data unit, owning data SRAM and peripherals.
// - Fetch and data units cross over a two-way system bus.
// - Top 4-Kbyte sector of first flash segment is withheld from users.
// - External I/O accesses are ordered and non-speculative.
// - CAN registers of the peripheral bus also decode at an alternate window; serial ones do not.
// - Program SRAM reached via fetch unit, with programmable write protection.
// - Data SRAM uses its own data-optimised interface.
// - Register bank of up to 16 words, lower eight byte addressable.
// - Top 256 bytes of dual-port RAM are bit addressable.
// - Any dual-port RAM word is bit addressable as an active-bank register.
// Assumes one request per unit per cycle; results are registered once.
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_defs.vh"

module memory_map_decoder (
    input wire clock,
    input wire rst_n,
    input wire fetch_req,
    input wire [`ADDR_W-1:0] fetch_addr,
    input wire data_req,
    input wire [`ADDR_W-1:0] data_addr,
    input wire data_write,
    input wire data_word,
    input wire data_bit,
    input wire data_gpr,
    input wire [3:0] data_gpr_num,
    input wire data_gpr_byte,
    input wire [`ADDR_W-1:0] context_base,
    input wire internal_mode,
    input wire [`WP_W-1:0] program_sram_wp_size,
    output reg [`TGT_W-1:0] fetch_target_q,
    output reg [`ADDR_W-1:0] fetch_local_q,
    output reg fetch_valid_q,
    output reg fetch_cross_q,
    output reg fetch_trap_q,
    output reg [`TGT_W-1:0] data_target_q,
    output reg [`ADDR_W-1:0] data_local_q,
    output reg [1:0] data_lanes_q,
    output reg data_valid_q,
    output reg data_cross_q,
    output reg data_trap_q,
    output reg data_ordered_q,
    output reg data_bit_ok_q,
    output reg [7:0] data_segment_q,
    output reg [1:0] data_page_q
);
    // ==========================================================
    // Helpers
    // ==========================================================
    function is_program_mem;
        input [`TGT_W-1:0] t;
        begin
            is_program_mem = (t == `TGT_FLASH) || (t == `TGT_PROGRAM_SRAM) || (t == `TGT_EPRAM);
        end
    endfunction

    function is_external;
        input [`TGT_W-1:0] t;
        begin
            is_external = (t == `TGT_EXT) || (t == `TGT_EXTIO) || (t == `TGT_LBUS);
        end
    endfunction

    // ==========================================================
    // General register address formation
    // ==========================================================
    reg [`ADDR_W-1:0] gpr_addr;
    wire [`ADDR_W-1:0] data_eff;
    always @* begin
        if (data_gpr_byte)
            gpr_addr = context_base + {20'h00000, data_gpr_num};
        else
            gpr_addr = context_base + {19'h00000, data_gpr_num, 1'b0};
    end
    assign data_eff = data_gpr ? gpr_addr : data_addr;

    // ==========================================================
    // Region decode for both units
    // ==========================================================
    wire [`TGT_W-1:0] f_tgt;
    wire [`ADDR_W-1:0] f_loc;
    wire f_resv;
    wire [`TGT_W-1:0] d_tgt;
    wire [`ADDR_W-1:0] d_loc;
    wire d_bit_ok;
    wire d_resv;
    wire [1:0] d_lanes;

    region_decode fetch_dec (
        .addr(fetch_addr),
        .target(f_tgt),
        .local_addr(f_loc),
        .bit_ok(),
        .reserved_flash(f_resv)
    );

    region_decode data_dec (
        .addr(data_eff),
        .target(d_tgt),
        .local_addr(d_loc),
        .bit_ok(d_bit_ok),
        .reserved_flash(d_resv)
    );

    lane_select data_lanes (
        .addr_lsb(data_eff[0]),
        .is_word(data_word | (data_gpr & ~data_gpr_byte)),
        .lanes(d_lanes)
    );

    // ==========================================================
    // Access checks
    // ==========================================================
    wire program_sram_protected;
    wire data_bit_legal;
    wire f_trap;
    wire d_trap;
    assign program_sram_protected = (d_tgt == `TGT_PROGRAM_SRAM) && data_write &&
        (d_loc[`WP_W-1:0] < program_sram_wp_size);
    assign data_bit_legal = ~data_bit | d_bit_ok |
        (data_gpr & (d_tgt == `TGT_DUAL_PORT_RAM));
    assign f_trap = (f_tgt == `TGT_TRAP) || (f_resv && !internal_mode);
    assign d_trap = (d_tgt == `TGT_TRAP) || (d_resv && !internal_mode) ||
        program_sram_protected || !data_bit_legal;

    // ==========================================================
    // Fetch unit routing
    // ==========================================================
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetch_target_q <= `TGT_NONE;
            fetch_local_q <= {`ADDR_W{1'b0}};
            fetch_valid_q <= 1'b0;
            fetch_cross_q <= 1'b0;
            fetch_trap_q <= 1'b0;
        end else begin
            fetch_valid_q <= fetch_req & ~f_trap;
            fetch_trap_q <= fetch_req & f_trap;
            fetch_target_q <= fetch_req ? f_tgt : `TGT_NONE;
            fetch_local_q <= fetch_req ? f_loc : {`ADDR_W{1'b0}};
            fetch_cross_q <= fetch_req & ~is_program_mem(f_tgt);
        end
    end

    // ==========================================================
    // Data unit routing
    // ==========================================================
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_target_q <= `TGT_NONE;
            data_local_q <= {`ADDR_W{1'b0}};
            data_lanes_q <= 2'h0;
            data_valid_q <= 1'b0;
            data_cross_q <= 1'b0;
            data_trap_q <= 1'b0;
            data_ordered_q <= 1'b0;
            data_bit_ok_q <= 1'b0;
            data_segment_q <= 8'h00;
            data_page_q <= 2'h0;
        end else begin
            data_valid_q <= data_req & ~d_trap;
            data_trap_q <= data_req & d_trap;
            data_target_q <= data_req ? d_tgt : `TGT_NONE;
            data_local_q <= data_req ? d_loc : {`ADDR_W{1'b0}};
            data_lanes_q <= data_req ? d_lanes : 2'h0;
            data_cross_q <= data_req & (is_program_mem(d_tgt) | is_external(d_tgt));
            data_ordered_q <= data_req & (d_tgt == `TGT_EXTIO);
            data_bit_ok_q <= data_req & data_bit_legal;
            data_segment_q <= data_eff[`SEG_HI:`SEG_LO];
            data_page_q <= data_eff[`PAGE_HI:`PAGE_LO];
        end
    end
endmodule // memory_map_decoder
`default_nettype wire

// File: core_model.sv
// Behavioural fetch and data units that issue requests to the decoder.
// Assumes a free-running clock; requests last one cycle each.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clock,
    output logic fetch_req,
    output logic [23:0] fetch_addr,
    output logic data_req,
    output logic [23:0] data_addr,
    output logic data_write,
    output logic data_word,
    output logic data_bit,
    output logic data_gpr,
    output logic [3:0] data_gpr_num,
    output logic data_gpr_byte
);
    initial begin
        {fetch_req, fetch_addr, data_req, data_addr} = '0;
        {data_write, data_word, data_bit, data_gpr, data_gpr_num, data_gpr_byte} = '0;
    end
    // Released address lines show the inverse so stale values never match
    task automatic fetch(input logic [23:0] a);
        @(posedge clock);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        @(posedge clock);
        fetch_req <= 1'b0;
        fetch_addr <= ~a;
    endtask
    // Flags are write, word, bit, general register, byte register
    task automatic data(input logic [23:0] a, input logic [4:0] f, input logic [3:0] n);
        @(posedge clock);
        data_req <= 1'b1;
        data_addr <= a;
        {data_write, data_word, data_bit, data_gpr, data_gpr_byte} <= f;
        data_gpr_num <= n;
        @(posedge clock);
        data_req <= 1'b0;
        data_addr <= ~a;
        data_gpr_num <= ~n;
    endtask
endmodule // core_model
`default_nettype wire

// File: map_monitor.sv
// Port checker for the memory map decoder.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module map_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fetch_req,
    input wire logic [23:0] fetch_addr,
    input wire logic data_req,
    input wire logic [23:0] data_addr,
    input wire logic data_word,
    input wire logic data_gpr,
    input wire logic internal_mode,
    input wire logic fetch_valid_q,
    input wire logic fetch_trap_q,
    input wire logic data_valid_q,
    input wire logic data_trap_q,
    input wire logic [1:0] data_lanes_q,
    input wire logic data_ordered_q,
    input wire logic [7:0] data_segment_q,
    input wire logic [1:0] data_page_q
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic d_ok = data_req && !data_gpr;
    wire logic io = data_addr >= 24'h210000 && data_addr <= 24'h3fffff;
    AST_DATA_ANSWER: assert property (data_req |=> data_valid_q != data_trap_q)
        else $error("data request without exactly one answer");
    AST_DATA_IDLE: assert property (!data_req |=> !data_valid_q && !data_trap_q)
        else $error("data answer without request");
    AST_FETCH_ANSWER: assert property (fetch_req |=> fetch_valid_q != fetch_trap_q)
        else $error("fetch request without exactly one answer");
    AST_SEGMENT: assert property (d_ok |=> data_segment_q == $past(data_addr[23:16]))
        else $error("segment field wrong");
    AST_PAGE: assert property (d_ok |=> data_page_q == $past(data_addr[15:14]))
        else $error("page field wrong");
    AST_WORD_LANES: assert property (data_req && data_word |=> !data_valid_q || data_lanes_q == 2'h3)
        else $error("word lanes wrong");
    AST_BYTE_LANES: assert property (d_ok && !data_word |=>
        !data_valid_q || data_lanes_q == ($past(data_addr[0]) ? 2'h2 : 2'h1))
        else $error("byte lanes wrong");
    AST_IO_ORDER: assert property (d_ok |=> data_ordered_q == $past(io))
        else $error("ordered flag wrong");
    AST_TOP_TRAP: assert property (d_ok && data_addr[23:20] == 4'hf && data_addr < 24'hffff00
        |=> data_trap_q)
        else $error("reserved top region not trapped");
    AST_FLASH_SECTOR: assert property (fetch_req && !internal_mode
        && fetch_addr[23:12] == 12'hc0f |=> fetch_trap_q)
        else $error("reserved flash sector fetched");
    cover property (d_ok ##1 data_trap_q);
    cover property (fetch_req ##1 fetch_valid_q);
    cover property (d_ok && io);
endmodule // map_monitor
bind memory_map_decoder map_monitor u_mon (.clock(clock), .rst_n(rst_n),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .data_req(data_req),
    .data_addr(data_addr), .data_word(data_word), .data_gpr(data_gpr),
    .internal_mode(internal_mode), .fetch_valid_q(fetch_valid_q),
    .fetch_trap_q(fetch_trap_q), .data_valid_q(data_valid_q), .data_trap_q(data_trap_q),
    .data_lanes_q(data_lanes_q), .data_ordered_q(data_ordered_q),
    .data_segment_q(data_segment_q), .data_page_q(data_page_q));
`default_nettype wire

// File: test_memory_map_decoder.sv
// Self-checking bench for the memory map decoder.
// Assumes core_model issues requests and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_defs.vh"
module test_memory_map_decoder;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic internal_mode = 1'b0;
    logic [23:0] context_base = 24'h00f600;
    logic [14:0] program_sram_wp_size = 15'h0000;
    wire logic fr, dr, dw, dwd, db, dg, dgb, fv, fc, ft, dv, dc, dt, dord, dbok;
    wire logic [23:0] fa, da, fl, dl;
    wire logic [3:0] dn, ftg, dtg;
    wire logic [1:0] dln, dpg;
    wire logic [7:0] dseg;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2.5 clock = ~clock;
    core_model u_core (.clock(clock), .fetch_req(fr), .fetch_addr(fa), .data_req(dr),
        .data_addr(da), .data_write(dw), .data_word(dwd), .data_bit(db), .data_gpr(dg),
        .data_gpr_num(dn), .data_gpr_byte(dgb));
    memory_map_decoder u_dut (.clock(clock), .rst_n(rst_n), .fetch_req(fr), .fetch_addr(fa),
        .data_req(dr), .data_addr(da), .data_write(dw), .data_word(dwd), .data_bit(db),
        .data_gpr(dg), .data_gpr_num(dn), .data_gpr_byte(dgb), .context_base(context_base),
        .internal_mode(internal_mode), .program_sram_wp_size(program_sram_wp_size), .fetch_target_q(ftg),
        .fetch_local_q(fl), .fetch_valid_q(fv), .fetch_cross_q(fc), .fetch_trap_q(ft),
        .data_target_q(dtg), .data_local_q(dl), .data_lanes_q(dln), .data_valid_q(dv),
        .data_cross_q(dc), .data_trap_q(dt), .data_ordered_q(dord), .data_bit_ok_q(dbok),
        .data_segment_q(dseg), .data_page_q(dpg));
    // ==========================================================
    // Shared checks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic dchk(input logic [23:0] a, input logic [4:0] f, input logic [3:0] n,
        input logic [3:0] tgt, input logic trap);
        u_core.data(a, f, n);
        #1;
        chk(dt, trap);
        chk(dv, !trap);
        if (!trap) chk(dtg, tgt);
    endtask
    task automatic fchk(input logic [23:0] a, input logic [3:0] tgt, input logic trap);
        u_core.fetch(a);
        #1;
        chk(ft, trap);
        chk(fv, !trap);
        if (!trap) chk(ftg, tgt);
    endtask
    task automatic t_walk;
        dchk(24'h00a002, 5'h08, 4'h0, `TGT_DATA_SRAM, 1'b0);
        chk(dl, 24'h000002);
        chk(dln, 2'h3);
        dchk(24'h00a003, 5'h00, 4'h0, `TGT_DATA_SRAM, 1'b0);
        chk(dln, 2'h2);
        @(posedge clock);
        #1;
        chk({dv, dt, dln}, 4'h0);
        $display("walk done");
    endtask
    task automatic t_map;
        logic [23:0] tr [7] = '{24'hf00000, 24'hfffeff, 24'hcd0000, 24'h20c000,
            24'h206000, 24'h00f200, 24'h008000};
        foreach (tr[i]) dchk(tr[i], 5'h08, 4'h0, `TGT_NONE, 1'b1);
        dchk(24'hffff00, 5'h08, 4'h0, `TGT_TOPREG, 1'b0);
        dchk(24'he08002, 5'h08, 4'h0, `TGT_PROGRAM_SRAM, 1'b0);
        chk({dl, dc}, {24'h000002, 1'b1});
        dchk(24'he88004, 5'h08, 4'h0, `TGT_EPRAM, 1'b0);
        chk(dl, 24'h000004);
        dchk(24'h208010, 5'h08, 4'h0, `TGT_LBUS, 1'b0);
        chk(dl, 24'h200010);
        dchk(24'h010000, 5'h00, 4'h0, `TGT_EXT, 1'b0);
        dchk(24'h400000, 5'h08, 4'h0, `TGT_EXT, 1'b0);
        dchk(24'h210000, 5'h08, 4'h0, `TGT_EXTIO, 1'b0);
        chk(dord, 1'b1);
        dchk(24'h12c456, 5'h00, 4'h0, `TGT_EXT, 1'b0);
        chk({dseg, dpg, dord}, {8'h12, 2'h3, 1'b0});
        dchk(24'h00e000, 5'h08, 4'h0, `TGT_PERIPHERAL_REGISTER_AREA, 1'b0);
        chk(dseg, 8'h00);
        $display("map done");
    endtask
    task automatic t_bits;
        dchk(24'h00fd00, 5'h04, 4'h0, `TGT_DUAL_PORT_RAM, 1'b0);
        chk(dbok, 1'b1);
        dchk(24'h00f600, 5'h04, 4'h0, `TGT_NONE, 1'b1);
        chk(dbok, 1'b0);
        dchk(24'h00f600, 5'h06, 4'h3, `TGT_DUAL_PORT_RAM, 1'b0);
        dchk(24'h000000, 5'h0a, 4'hf, `TGT_DUAL_PORT_RAM, 1'b0);
        dchk(24'h000000, 5'h03, 4'h5, `TGT_DUAL_PORT_RAM, 1'b0);
        chk(dln, 2'h2);
        dchk(24'h000000, 5'h03, 4'hf, `TGT_DUAL_PORT_RAM, 1'b0);
        chk({dl, dln}, {24'h00000f, 2'h2});
        program_sram_wp_size <= 15'h0100;
        dchk(24'he00010, 5'h10, 4'h0, `TGT_NONE, 1'b1);
        dchk(24'he00200, 5'h10, 4'h0, `TGT_PROGRAM_SRAM, 1'b0);
        $display("bits done");
    endtask
    task automatic t_fetch;
        fchk(24'hc00000, `TGT_FLASH, 1'b0);
        chk(fc, 1'b0);
        fchk(24'hc0f000, `TGT_NONE, 1'b1);
        internal_mode <= 1'b1;
        fchk(24'hc0f000, `TGT_FLASH, 1'b0);
        chk(fl, 24'h00f000);
        fchk(24'h00a000, `TGT_DATA_SRAM, 1'b0);
        chk(fc, 1'b1);
        $display("fetch done");
    endtask
    task automatic t_reset;
        dchk(24'h00a000, 5'h08, 4'h0, `TGT_DATA_SRAM, 1'b0);
        rst_n <= 1'b0;
        #1;
        chk({dv, dt, dtg, dln}, 8'h00);
        @(posedge clock);
        rst_n <= 1'b1;
        dchk(24'h00a004, 5'h08, 4'h0, `TGT_DATA_SRAM, 1'b0);
        $display("reset done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_walk;
        t_map;
        t_bits;
        t_fetch;
        t_reset;
        finish_test;
    end
endmodule // test_memory_map_decoder
`default_nettype wire
